// ==== src/board_watchdog_map.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the board
  watchdog with run indicator. Assumes a 250 MHz block clock.
*/
`ifndef BOARD_WATCHDOG_MAP_SVH
`define BOARD_WATCHDOG_MAP_SVH

`define WD_INDEX_PORT_ADDR      8'h45
`define WD_DATA_PORT_ADDR       8'h46
`define WD_CONFIG_INDEX         8'h0b
`define WD_TRIGGER_INDEX        8'h55
`define WD_KILL_VALUE           8'h55

`define WD_ARM_BIT              0
`define WD_TSEL_LSB             1
`define WD_TSEL_MSB             3
`define WD_FLAG_BIT             4
`define WD_RUN_LSB              6
`define WD_RUN_MSB              7

`define WD_CONFIG_RESET         8'h00

`define WD_CLOCK_HZ             250000000
`define WD_BASE_TIMEOUT_MS      250
`define WD_BASE_TIMEOUT_CYCLES  ((`WD_CLOCK_HZ / 1000) * `WD_BASE_TIMEOUT_MS)
`define WD_TIMEOUT_CODE5_MS     8100
`define WD_TIMEOUT_CODE6_MS     16100
`define WD_TIMEOUT_CODE7_MS     32200
`define WD_FLASH_1HZ_HALF_MS    500
`define WD_FLASH_2HZ_HALF_MS    250
`define WD_RESET_PULSE_CYCLES   16

`endif

// ==== src/board_watchdog_pkg.sv ====
/*
  Types for the board watchdog. Constants live in board_watchdog_map.svh.
*/
package board_watchdog_pkg;
    typedef enum logic [1:0] {
        RUN_OFF,
        RUN_ON,
        RUN_FLASH_1HZ,
        RUN_FLASH_2HZ
    } run_mode_e;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_ARMED,
        WD_RUNNING
    } wd_state_e;
endpackage : board_watchdog_pkg

// ==== src/board_watchdog.sv ====
/*
  Board watchdog with run indicator, reached over an 8-bit index/data I/O port pair.
  Assumes a single 250 MHz clock, io strobes synchronous to it, one cycle long,
  and that the generated boardReset feeds the board reset tree outside rst_b so
  that the reset-occurred flag survives it.
*/
// Summary of operation
// - Timeout while running asserts board reset.
// - Bits 7:6 select LED off/on/1Hz/2Hz.
// - Bits 3:1 select 0.25s to 32.2s timeout.
// - Arm bit arms but does not start.
// - Next trigger write starts countdown after arming.
// - Reset-occurred flag set by watchdog reset.
// - Flag clears only on rst_b or after writing one then zero.
// - Watchdog idle until first trigger event.
// - Writing 55h to trigger resets board immediately while the arm bit is set.
`include "board_watchdog_map.svh"
`timescale 1ns/10ps
`default_nettype none

module board_watchdog #(
    parameter int unsigned BASE_CYCLES = `WD_BASE_TIMEOUT_CYCLES,
    parameter int unsigned HALF_1HZ    = (`WD_CLOCK_HZ / 1000) * `WD_FLASH_1HZ_HALF_MS,
    parameter int unsigned HALF_2HZ    = (`WD_CLOCK_HZ / 1000) * `WD_FLASH_2HZ_HALF_MS
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       ioWrite,
    input  wire logic       ioRead,
    input  wire logic [7:0] ioAddr,
    input  wire logic [7:0] ioWriteData,
    output logic      [7:0] ioReadData,
    output logic            boardReset,
    output logic            runLed
);
    logic [7:0]  index_reg, index_next;
    logic [7:0]  cfg_reg, cfg_next;
    logic        flagOneSeen_reg, flagOneSeen_next;
    logic [7:0]  rdata_reg, rdata_next;
    board_watchdog_pkg::wd_state_e state_reg, state_next;
    logic [35:0] count_reg, count_next;
    logic [4:0]  rstCnt_reg, rstCnt_next;
    logic [31:0] blink_reg, blink_next;
    logic        blinkLvl_reg, blinkLvl_next;

    logic        dataWr;
    logic        cfgWr;
    logic        trigWr;
    logic        fire;
    logic [35:0] reload;
    logic [31:0] halfPeriod;

    // Products are formed at 36 bits: 32.2 s of full-rate cycles overflows 32 bits.
    localparam logic [35:0] MS_CYCLES = 36'(BASE_CYCLES / `WD_BASE_TIMEOUT_MS);

    assign dataWr = ioWrite && (ioAddr == `WD_DATA_PORT_ADDR);
    assign cfgWr  = dataWr && (index_reg == `WD_CONFIG_INDEX);
    assign trigWr = dataWr && (index_reg == `WD_TRIGGER_INDEX);

    // Codes 5..7 are not exact doublings, so they take their own printed times.
    always_comb begin
        case (cfg_reg[`WD_TSEL_MSB:`WD_TSEL_LSB])
            3'h5:    reload = MS_CYCLES * 36'(`WD_TIMEOUT_CODE5_MS);
            3'h6:    reload = MS_CYCLES * 36'(`WD_TIMEOUT_CODE6_MS);
            3'h7:    reload = MS_CYCLES * 36'(`WD_TIMEOUT_CODE7_MS);
            default: reload = 36'(BASE_CYCLES) << cfg_reg[`WD_TSEL_MSB:`WD_TSEL_LSB];
        endcase
    end

    always_comb begin
        index_next       = index_reg;
        cfg_next         = cfg_reg;
        flagOneSeen_next = flagOneSeen_reg;
        rdata_next       = rdata_reg;
        if (ioWrite && (ioAddr == `WD_INDEX_PORT_ADDR)) begin
            index_next = ioWriteData;
        end
        if (ioRead && (ioAddr == `WD_DATA_PORT_ADDR)) begin
            rdata_next = (index_reg == `WD_CONFIG_INDEX) ? cfg_reg : 8'h00;
        end
        if (cfgWr) begin
            cfg_next[`WD_RUN_MSB:`WD_RUN_LSB]   = ioWriteData[`WD_RUN_MSB:`WD_RUN_LSB];
            cfg_next[`WD_TSEL_MSB:`WD_TSEL_LSB] = ioWriteData[`WD_TSEL_MSB:`WD_TSEL_LSB];
            cfg_next[`WD_ARM_BIT]               = ioWriteData[`WD_ARM_BIT];
            if (ioWriteData[`WD_FLAG_BIT]) begin
                flagOneSeen_next = 1'b1;
            end else if (flagOneSeen_reg) begin
                cfg_next[`WD_FLAG_BIT] = 1'b0;
                flagOneSeen_next       = 1'b0;
            end
        end
        // A watchdog reset in the same cycle as a clear keeps the flag set.
        if (fire) begin
            cfg_next[`WD_FLAG_BIT] = 1'b1;
        end
        cfg_next[5] = 1'b0;
    end

    always_comb begin
        state_next  = state_reg;
        count_next  = count_reg;
        rstCnt_next = (rstCnt_reg != 5'h00) ? rstCnt_reg - 5'h01 : 5'h00;
        fire        = 1'b0;
        case (state_reg)
            board_watchdog_pkg::WD_IDLE: begin
                if (cfg_reg[`WD_ARM_BIT]) begin
                    state_next = board_watchdog_pkg::WD_ARMED;
                end
            end
            board_watchdog_pkg::WD_ARMED: begin
                if (!cfg_reg[`WD_ARM_BIT]) begin
                    state_next = board_watchdog_pkg::WD_IDLE;
                end else if (trigWr) begin
                    state_next = board_watchdog_pkg::WD_RUNNING;
                    count_next = reload;
                end
            end
            board_watchdog_pkg::WD_RUNNING: begin
                if (!cfg_reg[`WD_ARM_BIT]) begin
                    state_next = board_watchdog_pkg::WD_IDLE;
                end else if (trigWr) begin
                    count_next = reload;
                end else if (count_reg <= 36'h1) begin
                    fire = 1'b1;
                end else begin
                    count_next = count_reg - 36'h1;
                end
            end
            default: state_next = board_watchdog_pkg::WD_IDLE;
        endcase
        if (trigWr && (ioWriteData == `WD_KILL_VALUE) && cfg_reg[`WD_ARM_BIT]) begin
            fire = 1'b1;
        end
        if (fire) begin
            state_next  = board_watchdog_pkg::WD_IDLE;
            rstCnt_next = 5'(`WD_RESET_PULSE_CYCLES);
        end
    end

    always_comb begin
        case (board_watchdog_pkg::run_mode_e'(cfg_reg[`WD_RUN_MSB:`WD_RUN_LSB]))
            board_watchdog_pkg::RUN_FLASH_1HZ: halfPeriod = HALF_1HZ;
            default:                           halfPeriod = HALF_2HZ;
        endcase
        blinkLvl_next = blinkLvl_reg;
        blink_next    = blink_reg + 32'h1;
        if (blink_reg >= halfPeriod - 32'h1) begin
            blink_next    = 32'h0;
            blinkLvl_next = !blinkLvl_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            index_reg       <= 8'h00;
            cfg_reg         <= `WD_CONFIG_RESET;
            flagOneSeen_reg <= 1'b0;
            rdata_reg       <= 8'h00;
            state_reg       <= board_watchdog_pkg::WD_IDLE;
            count_reg       <= 36'h0;
            rstCnt_reg      <= 5'h00;
            blink_reg       <= 32'h0;
            blinkLvl_reg    <= 1'b0;
        end else begin
            index_reg       <= index_next;
            cfg_reg         <= cfg_next;
            flagOneSeen_reg <= flagOneSeen_next;
            rdata_reg       <= rdata_next;
            state_reg       <= state_next;
            count_reg       <= count_next;
            rstCnt_reg      <= rstCnt_next;
            blink_reg       <= blink_next;
            blinkLvl_reg    <= blinkLvl_next;
        end
    end

    assign ioReadData = rdata_reg;
    assign boardReset = (rstCnt_reg != 5'h00);
    always_comb begin
        case (board_watchdog_pkg::run_mode_e'(cfg_reg[`WD_RUN_MSB:`WD_RUN_LSB]))
            board_watchdog_pkg::RUN_OFF: runLed = 1'b0;
            board_watchdog_pkg::RUN_ON:  runLed = 1'b1;
            default:                     runLed = blinkLvl_reg;
        endcase
    end

    kill_fires_a: assert property (@(posedge clock) disable iff (!rst_b)
        (trigWr && ioWriteData == `WD_KILL_VALUE && cfg_reg[`WD_ARM_BIT]) |=> boardReset)
        else $error("kill value did not reset board");

    no_start_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_reg == board_watchdog_pkg::WD_ARMED && !trigWr)
        |=> state_reg != board_watchdog_pkg::WD_RUNNING)
        else $error("countdown started without trigger");

    start_load_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_reg == board_watchdog_pkg::WD_ARMED && cfg_reg[`WD_ARM_BIT] && trigWr
         && ioWriteData != `WD_KILL_VALUE) |=> (state_reg == board_watchdog_pkg::WD_RUNNING
         && count_reg == $past(reload)))
        else $error("trigger did not start countdown");

    reload_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_reg == board_watchdog_pkg::WD_RUNNING && cfg_reg[`WD_ARM_BIT] && trigWr
         && ioWriteData != `WD_KILL_VALUE) |=> count_reg == $past(reload))
        else $error("trigger did not reload");

    timeout_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_reg == board_watchdog_pkg::WD_RUNNING && cfg_reg[`WD_ARM_BIT] && !trigWr
         && count_reg == 36'h1) |=> (boardReset && cfg_reg[`WD_FLAG_BIT]))
        else $error("timeout did not reset board");

    idle_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
        (state_reg == board_watchdog_pkg::WD_IDLE && !trigWr && rstCnt_reg == 5'h00)
        |=> !boardReset)
        else $error("reset while idle");

    sequence flagOneWrite;
        cfgWr && ioWriteData[`WD_FLAG_BIT] && !fire;
    endsequence
    flag_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
        (cfgWr && !ioWriteData[`WD_FLAG_BIT] && !flagOneSeen_reg && !fire && cfg_reg[`WD_FLAG_BIT])
        |=> cfg_reg[`WD_FLAG_BIT])
        else $error("flag cleared without one first");

    sequence flagZeroAfterOne;
        cfgWr && !ioWriteData[`WD_FLAG_BIT] && flagOneSeen_reg && !fire;
    endsequence
    flag_one_a: assert property (@(posedge clock) disable iff (!rst_b)
        flagOneWrite |=> flagOneSeen_reg)
        else $error("one write to flag not remembered");

    // Software reaches the config one port write at a time, so the zero never follows the
    // one on the next cycle; the remembered one carries the first step across the gap.
    flag_seq_a: assert property (@(posedge clock) disable iff (!rst_b)
        flagZeroAfterOne |=> !cfg_reg[`WD_FLAG_BIT])
        else $error("one-then-zero did not clear flag");

    led_mode_a: assert property (@(posedge clock) disable iff (!rst_b)
        (cfg_reg[`WD_RUN_MSB:`WD_RUN_LSB] == 2'h1) |-> runLed)
        else $error("led not on in on mode");
endmodule : board_watchdog

`default_nettype wire

// ==== dv/host_io_model.sv ====
/* Host processor model driving the index/data I/O port pair of the watchdog.
   Assumes the bench calls its tasks one at a time, and the block's clock. */
`timescale 1ns/10ps
`default_nettype none
module host_io_model (
    input  wire logic       clock,
    output logic            ioWrite,
    output logic            ioRead,
    output logic      [7:0] ioAddr,
    output logic      [7:0] ioWriteData,
    input  wire logic [7:0] ioReadData
);
    initial begin
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioAddr = 8'h00;
        ioWriteData = 8'h00;
    end
    // A released data bus shows the inverse, so stale data is never mistaken for fresh.
    task automatic portWrite(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        ioAddr = addr;
        ioWriteData = data;
        ioWrite = 1'b1;
        @(negedge clock);
        ioWrite = 1'b0;
        ioWriteData = ~data;
    endtask : portWrite
    task automatic portRead(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock);
        ioAddr = addr;
        ioRead = 1'b1;
        @(negedge clock);
        ioRead = 1'b0;
        data = ioReadData;
    endtask : portRead
    task automatic cfgRead(output logic [7:0] data);
        portWrite(8'h45, 8'h0b);
        portRead(8'h46, data);
    endtask : cfgRead
    task automatic cfgWrite(input logic [7:0] value, input logic keepLed);
        logic [7:0] old;
        cfgRead(old);
        if (keepLed) begin
            value[7:6] = old[7:6];
        end
        portWrite(8'h46, value);
    endtask : cfgWrite
    task automatic trigger(input logic [7:0] data);
        portWrite(8'h45, 8'h55);
        portWrite(8'h46, data);
    endtask : trigger
endmodule : host_io_model
`default_nettype wire

// ==== dv/test_board_watchdog.sv ====
/* Self-checking bench of the board watchdog, driven through the host model.
   Assumes shortened timing parameters so that every timeout code 0..7 runs quickly. */
`timescale 1ns/10ps
`default_nettype none
module test_board_watchdog;
    localparam int BASE  = 250;
    localparam int HALF1 = 8;
    localparam int HALF2 = 4;
    logic       clock;
    logic       rst_b;
    logic       ioWrite;
    logic       ioRead;
    logic [7:0] ioAddr;
    logic [7:0] ioWriteData;
    logic [7:0] ioReadData;
    logic       boardReset;
    logic       runLed;
    int         fail_count;
    int         compares;
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    board_watchdog #(.BASE_CYCLES(BASE), .HALF_1HZ(HALF1), .HALF_2HZ(HALF2)) i_board_watchdog (
        .clock(clock), .rst_b(rst_b), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
        .ioWriteData(ioWriteData), .ioReadData(ioReadData), .boardReset(boardReset),
        .runLed(runLed));
    host_io_model i_host_io_model (.clock(clock), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioAddr(ioAddr), .ioWriteData(ioWriteData), .ioReadData(ioReadData));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // Counts cycles until boardReset rises; running out of the bound ends the run.
    task automatic waitReset(input int lim, output int n);
        n = 0;
        while (boardReset !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        if (n >= lim) begin
            check("reset wait", 8'h00, 8'h01);
            finish_test();
        end
    endtask : waitReset
    task automatic watch(input int cyc, output int hi, output int tg);
        logic last;
        hi = 0;
        tg = 0;
        last = runLed;
        repeat (cyc) begin
            @(negedge clock);
            hi += (boardReset === 1'b1 || runLed === 1'b1) ? 1 : 0;
            tg += (runLed !== last) ? 1 : 0;
            last = runLed;
        end
    endtask : watch
    initial begin
        logic [7:0] d;
        int n;
        int hi;
        int tg;
        int expHi[4] = '{0, 64, 32, 32};
        int expTg[4] = '{0, 0, 8, 16};
        // Printed periods in ms; BASE cycles stand for 250 ms.
        int expMs[8] = '{250, 500, 1000, 2000, 4000, 8100, 16100, 32200};
        int expCyc;
        rst_b = 1'b0;
        fail_count = 0;
        compares = 0;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        i_host_io_model.cfgRead(d);
        check("config reset", d, 8'h00);
        for (int m = 0; m < 4; m++) begin
            i_host_io_model.cfgWrite(8'(m << 6) | 8'h2e, 1'b0);
            i_host_io_model.cfgRead(d);
            check("config readback", d, 8'(m << 6) | 8'h0e);
            watch(64, hi, tg);
            check("led high", 8'(hi), 8'(expHi[m]));
            check("led toggles", 8'(tg >= expTg[m] - 1 && tg <= expTg[m] + 1), 8'h01);
        end
        for (int c = 0; c < 8; c++) begin
            expCyc = expMs[c] * BASE / 250;
            i_host_io_model.cfgWrite(8'(c * 2 + 1), 1'b0);
            watch(BASE * 2, hi, tg);
            check("armed idle", 8'(hi), 8'h00);
            i_host_io_model.trigger(8'h00);
            if (c == 0) begin
                repeat (BASE - 50) @(negedge clock);
                i_host_io_model.trigger(8'ha5);
            end
            waitReset(expCyc * 2, n);
            check("timeout", 8'(n >= expCyc - 4 && n <= expCyc + 4), 8'h01);
            watch(20, hi, tg);
            // The first high cycle of the pulse was already seen by waitReset.
            check("pulse", 8'(hi + 1), 8'h10);
            i_host_io_model.cfgRead(d);
            check("flag set", d, 8'(c * 2 + 1) | 8'h10);
            i_host_io_model.cfgWrite(8'h10, 1'b1);
            i_host_io_model.cfgRead(d);
            check("flag after one", d, 8'h10);
            i_host_io_model.cfgWrite(8'h00, 1'b1);
            i_host_io_model.cfgRead(d);
            check("flag cleared", d, 8'h00);
        end
        i_host_io_model.trigger(8'h55);
        watch(BASE * 2, hi, tg);
        check("disarmed kill", 8'(hi), 8'h00);
        i_host_io_model.cfgWrite(8'h01, 1'b1);
        i_host_io_model.trigger(8'h55);
        waitReset(40, n);
        check("kill at once", 8'(n <= 3), 8'h01);
        watch(20, hi, tg);
        check("kill pulse", 8'(hi + 1), 8'h10);
        i_host_io_model.cfgRead(d);
        check("kill flag", d, 8'h11);
        // A reset in mid-countdown must leave the watchdog idle with a cleared config.
        i_host_io_model.trigger(8'h00);
        rst_b = 1'b0;
        repeat (4) @(negedge clock);
        rst_b = 1'b1;
        watch(BASE * 2, hi, tg);
        check("reset stops countdown", 8'(hi), 8'h00);
        i_host_io_model.cfgRead(d);
        check("config after reset", d, 8'h00);
        finish_test();
    end
endmodule : test_board_watchdog
`default_nettype wire
